/* rtl/gplog_fifo.sv */
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock and a synchronous active-high reset; DEPTH is a
  power of two.
*/
`timescale 1ns/1ps
module gplog_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic full, empty;

  // pointers carry one extra wrap bit so full and empty are distinct
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  // next pointers and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (in_valid_i && !full) begin
      mem_d[wr_q[AW-1:0]] = in_data_i;
      wr_d = wr_q + 1'b1;
    end
    if (out_ready_i && !empty) begin
      rd_d = rd_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end
endmodule : gplog_fifo

/* rtl/log_reader.sv */
/*
  Extended log-read command handler: checks the request, then streams the
  selected log sectors byte by byte through a FIFO, and keeps the extended
  error log. Assumes the command parameters are stable while cmd_start_i
  is high and that all inputs are synchronous to core_clk_i.
*/
`timescale 1ns/1ps
`include "gplog_defines.svh"
module log_reader import gplog_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // command taken from the task file
  input wire logic cmd_start_i,
  input wire logic [7:0] log_addr_i,
  input wire logic [7:0] scnt_cur_i,
  input wire logic [7:0] scnt_prev_i,
  input wire logic [7:0] first_cur_i,
  input wire logic [7:0] first_prev_i,
  input wire logic smart_en_i,
  // device error reports
  input wire logic err_event_i,
  input wire logic err_faulty_i,
  input wire logic [7:0] err_reg_i,
  input wire logic [7:0] err_status_i,
  // log data stream
  output logic [7:0] data_o,
  output logic data_valid_o,
  input wire logic data_ready_i,
  // command status
  output logic drq_irq_o,
  output logic done_o,
  output logic abort_o,
  output logic busy_o
);
  // --------------------------------------------------------------------------
  // log sizes
  // --------------------------------------------------------------------------
  // sectors in each log; zero for anything not served here
  function automatic logic [15:0] log_sectors(input logic [7:0] a, input logic en);
    logic [15:0] n;
    n = '0;
    if (a == `LOG_DIR) n = `ONE_SECTOR;
    else if (en && (a == `LOG_ERR || a == `LOG_TEST)) n = `ONE_SECTOR;
    else if (en && a >= `LOG_VEND_LO && a <= `LOG_VEND_HI) n = `VEND_SECTORS;
    return n;
  endfunction : log_sectors

  // --------------------------------------------------------------------------
  // command sequencer
  // --------------------------------------------------------------------------
  rd_state_t state_q, state_d;
  logic [7:0] addr_q, addr_d;
  logic [15:0] cnt_q, cnt_d, first_q, first_d, sect_q, sect_d, left_q, left_d;
  logic [8:0] byte_q, byte_d;
  logic [7:0] sum_q, sum_d;
  logic irq_q, irq_d, done_q, done_d, abort_q, abort_d, busy_q, busy_d;
  logic [16:0] end_sect;
  logic [15:0] size;
  logic bad, push, fifo_ready;
  logic [7:0] gen_byte;
  assign size = log_sectors(addr_q, smart_en_i);
  assign end_sect = {1'b0, first_q} + {1'b0, cnt_q};
  // invalid count, address or start, disabled feature, or the legacy log
  assign bad = (addr_q == `LOG_TEST_OLD) || (size == '0) || (cnt_q == '0)
    || (first_q >= size) || (end_sect > {1'b0, size});
  assign push = (state_q == ST_SEND);
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    first_d = first_q;
    sect_d = sect_q;
    left_d = left_q;
    byte_d = byte_q;
    sum_d = sum_q;
    irq_d = 1'b0;
    done_d = 1'b0;
    abort_d = 1'b0;
    busy_d = busy_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_start_i) begin
          addr_d = log_addr_i;
          cnt_d = {scnt_prev_i, scnt_cur_i};
          first_d = {first_prev_i, first_cur_i};
          busy_d = 1'b1;
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (bad) begin
          abort_d = 1'b1;
          busy_d = 1'b0;
          state_d = ST_IDLE;
        end else begin
          sect_d = first_q;
          left_d = cnt_q;
          byte_d = '0;
          sum_d = '0;
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (fifo_ready) begin
          sum_d = sum_q + gen_byte;
          if (byte_q == '0) irq_d = 1'b1;
          if (byte_q == `LAST_BYTE) begin
            byte_d = '0;
            sum_d = '0;
            sect_d = sect_q + 1'b1;
            left_d = left_q - 1'b1;
            if (left_q == `ONE_SECTOR) begin
              done_d = 1'b1;
              busy_d = 1'b0;
              state_d = ST_IDLE;
            end
          end else begin
            byte_d = byte_q + 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      cnt_q <= '0;
      first_q <= '0;
      sect_q <= '0;
      left_q <= '0;
      byte_q <= '0;
      sum_q <= '0;
      irq_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      sect_q <= sect_d;
      left_q <= left_d;
      byte_q <= byte_d;
      sum_q <= sum_d;
      irq_q <= irq_d;
      done_q <= done_d;
      abort_q <= abort_d;
      busy_q <= busy_d;
    end
  end
  // --------------------------------------------------------------------------
  // extended error log state
  // --------------------------------------------------------------------------
  logic [2:0] idx_q, idx_d;
  logic [7:0] ereg_q [4];
  logic [7:0] ereg_d [4];
  logic [7:0] estat_q [4];
  logic [7:0] estat_d [4];
  logic [15:0] ecnt_q, ecnt_d;
  logic [1:0] slot;
  // index is one-based; after the fourth entry the ring wraps to slot 0
  assign slot = (idx_q == `ERR_ENTRIES) ? 2'h0 : idx_q[1:0];
  always_comb begin
    idx_d = idx_q;
    ereg_d = ereg_q;
    estat_d = estat_q;
    ecnt_d = ecnt_q;
    // faulty commands are neither logged nor counted
    if (err_event_i && !err_faulty_i) begin
      ereg_d[slot] = err_reg_i;
      estat_d[slot] = err_status_i;
      idx_d = {1'b0, slot} + 3'h1;
      if (ecnt_q != `CNT_MAX) ecnt_d = ecnt_q + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      idx_q <= '0;
      ecnt_q <= '0;
      for (int i = 0; i < 4; i++) begin
        ereg_q[i] <= '0;
        estat_q[i] <= '0;
      end
    end else begin
      idx_q <= idx_d;
      ecnt_q <= ecnt_d;
      ereg_q <= ereg_d;
      estat_q <= estat_d;
    end
  end
  // --------------------------------------------------------------------------
  // sector byte generator
  // --------------------------------------------------------------------------
  logic [15:0] dir_cnt;
  assign dir_cnt = log_sectors(byte_q[8:1], smart_en_i);
  // vendor logs have no write path here, so they read as zeros
  always_comb begin
    gen_byte = '0;
    if (addr_q == `LOG_DIR) begin
      if (byte_q[8:1] == '0)
        gen_byte = byte_q[0] ? 8'(`DIR_VERSION >> 8) : 8'(`DIR_VERSION);
      else gen_byte = byte_q[0] ? dir_cnt[15:8] : dir_cnt[7:0];
    end else if (addr_q == `LOG_ERR) begin
      if (byte_q == '0) gen_byte = `LOG_VERSION;
      if (byte_q == `IDX_OFS) gen_byte = {5'h00, idx_q};
      for (int e = 0; e < 4; e++) begin
        if (byte_q == 9'(`ENTRY0_OFS + e * `ENTRY_LEN + `ERR_DS_OFS + `ERR_REG_OFS))
          gen_byte = ereg_q[e];
        if (byte_q == 9'(`ENTRY0_OFS + e * `ENTRY_LEN + `ERR_DS_OFS + `ERR_STAT_OFS))
          gen_byte = estat_q[e];
      end
      if (byte_q == `ERR_CNT_OFS) gen_byte = ecnt_q[7:0];
      if (byte_q == `ERR_CNT_OFS + 9'h001) gen_byte = ecnt_q[15:8];
      if (byte_q == `LAST_BYTE) gen_byte = 8'h00 - sum_q;
    end else if (addr_q == `LOG_TEST) begin
      // no self-tests recorded: 48-bit and 28-bit descriptors alike are zero
      if (byte_q == '0) gen_byte = `LOG_VERSION;
      if (byte_q == `LAST_BYTE) gen_byte = 8'h00 - sum_q;
    end
  end
  // --------------------------------------------------------------------------
  // data path: FIFO then output register
  // --------------------------------------------------------------------------
  logic fifo_valid, take;
  logic [7:0] fifo_data;
  logic [7:0] data_q, data_d;
  logic dvalid_q, dvalid_d;
  // the output register only refills when empty or being drained
  assign take = fifo_valid && (!dvalid_q || data_ready_i);
  gplog_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(push),
    .in_data_i(gen_byte),
    .in_ready_o(fifo_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(take)
  );
  always_comb begin
    data_d = data_q;
    dvalid_d = dvalid_q && !data_ready_i;
    if (take) begin
      data_d = fifo_data;
      dvalid_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      data_q <= '0;
      dvalid_q <= 1'b0;
    end else begin
      data_q <= data_d;
      dvalid_q <= dvalid_d;
    end
  end
  assign data_o = data_q;
  assign data_valid_o = dvalid_q;
  assign drq_irq_o = irq_q;
  assign done_o = done_q;
  assign abort_o = abort_q;
  assign busy_o = busy_q;
  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_accept;
    state_q == ST_IDLE && cmd_start_i;
  endsequence
  sequence s_good_check;
    state_q == ST_CHECK && !bad;
  endsequence
  sequence s_push_first;
    push && fifo_ready && byte_q == '0;
  endsequence
  a_count_latch: assert property (s_accept |=>
      cnt_q == {$past(scnt_prev_i), $past(scnt_cur_i)}) else $error("sector count bytes misplaced");
  a_first_latch: assert property (s_accept |=>
      first_q == {$past(first_prev_i), $past(first_cur_i)}) else $error("first sector misplaced");
  a_log_select: assert property (s_accept |=> addr_q == $past(log_addr_i))
    else $error("log address not taken from sector number");
  a_start_sector: assert property (s_good_check |=> state_q == ST_SEND
      && sect_q == $past(first_q)) else $error("transfer did not begin at requested sector");
  a_legacy_abort: assert property (state_q == ST_CHECK && addr_q == `LOG_TEST_OLD
      |=> abort_o && !busy_o) else $error("log 06h not aborted");
  a_zero_count: assert property (state_q == ST_CHECK && cnt_q == '0
      |=> abort_o ##1 !abort_o) else $error("zero sector count not aborted once");
  a_vendor_size: assert property (state_q == ST_CHECK && smart_en_i && first_q == 16'h000F
      && addr_q >= `LOG_VEND_LO && addr_q <= `LOG_VEND_HI && cnt_q == `ONE_SECTOR
      |=> !abort_o && state_q == ST_SEND) else $error("vendor log not sixteen sectors long");
  a_dir_version: assert property (s_push_first and addr_q == `LOG_DIR
      |-> gen_byte == 8'(`DIR_VERSION)) else $error("directory version low byte wrong");
  a_block_irq: assert property (s_push_first |=> drq_irq_o ##1 !drq_irq_o)
    else $error("no single interrupt at sector start");
  a_index_range: assert property (idx_q <= `ERR_ENTRIES && (ecnt_q != '0 || idx_q == '0))
    else $error("error index out of range");
  a_count_sat: assert property (ecnt_q == `CNT_MAX |=> ecnt_q == `CNT_MAX)
    else $error("error count wrapped");
  a_faulty_skip: assert property (err_event_i && err_faulty_i
      |=> $stable(ecnt_q) && $stable(idx_q)) else $error("faulty command was logged");
  a_checksum: assert property (push && fifo_ready && byte_q == `LAST_BYTE
      && (addr_q == `LOG_ERR || addr_q == `LOG_TEST) |-> 8'(sum_q + gen_byte) == 8'h00)
    else $error("log sector sum not zero");
endmodule : log_reader

/* shared/gplog_defines.svh */
/*
  Constants of the extended log-read handler: log addresses, sector layouts
  and fixed field values. Assumes 512-byte sectors and byte-wide indexing.
*/
`ifndef GPLOG_DEFINES_SVH
`define GPLOG_DEFINES_SVH

// --------------------------------------------------------------------------
// log addresses and sizes
// --------------------------------------------------------------------------
`define LOG_DIR 8'h00
`define LOG_ERR 8'h03
`define LOG_TEST_OLD 8'h06
`define LOG_TEST 8'h07
`define LOG_VEND_LO 8'h80
`define LOG_VEND_HI 8'h9F
`define ONE_SECTOR 16'h0001
`define VEND_SECTORS 16'h0010

// --------------------------------------------------------------------------
// sector layout
// --------------------------------------------------------------------------
`define LAST_BYTE 9'h1FF
`define DIR_VERSION 16'h0001
`define LOG_VERSION 8'h01
`define IDX_OFS 9'h002
`define ENTRY0_OFS 9'h004
`define ENTRY_LEN 9'h07C
`define ERR_DS_OFS 9'h05A
`define ERR_REG_OFS 9'h001
`define ERR_STAT_OFS 9'h00B
`define ERR_CNT_OFS 9'h1F4
`define ERR_ENTRIES 3'h4
`define CNT_MAX 16'hFFFF

`endif

/* shared/gplog_pkg.sv */
/*
  Types of the extended log-read handler.
  Assumes nothing beyond the defines header.
*/
package gplog_pkg;
  // command sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_SEND} rd_state_t;
endpackage : gplog_pkg

/* verif/general_purpose_log_reader_tb.sv */
/*
  Self-checking bench of the extended log-read handler.
  Assumes the defines header on the include path; inputs move at falling edges.
*/
`timescale 1ns/1ps
`include "gplog_defines.svh"
module general_purpose_log_reader_tb;
  logic core_clk_i, reset_i, cmd_start_i, smart_en_i, err_event_i, err_faulty_i, stall;
  logic [7:0] log_addr_i, scnt_cur_i, scnt_prev_i, first_cur_i, first_prev_i;
  logic [7:0] err_reg_i, err_status_i, data_o;
  logic data_valid_o, data_ready_i, drq_irq_o, done_o, abort_o, busy_o;
  int fail_count, check_count, drq_cnt, nerr;
  logic [15:0] rnd;
  logic [7:0] ereg [4];
  logic [7:0] estat [4];
  // requests that must be refused
  logic [7:0] ab_a [8] = '{8'h06, 8'h10, 8'h11, 8'h21, 8'h00, 8'h00, 8'h80, 8'hA0};
  logic [15:0] ab_c [8] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h0, 16'h1, 16'h2, 16'h1};
  logic [15:0] ab_f [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'hF, 16'h0};

  log_reader #(.FIFO_DEPTH(8)) uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .cmd_start_i(cmd_start_i), .log_addr_i(log_addr_i), .scnt_cur_i(scnt_cur_i),
    .scnt_prev_i(scnt_prev_i), .first_cur_i(first_cur_i), .first_prev_i(first_prev_i),
    .smart_en_i(smart_en_i), .err_event_i(err_event_i), .err_faulty_i(err_faulty_i),
    .err_reg_i(err_reg_i), .err_status_i(err_status_i), .data_o(data_o),
    .data_valid_o(data_valid_o), .data_ready_i(data_ready_i), .drq_irq_o(drq_irq_o),
    .done_o(done_o), .abort_o(abort_o), .busy_o(busy_o));

  log_sink sink (.core_clk_i(core_clk_i), .reset_i(reset_i), .byte_i(data_o),
    .valid_i(data_valid_o), .ready_o(data_ready_i), .stall_i(stall));

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // block interrupts seen since time zero
  always @(posedge core_clk_i) begin
    if (drq_irq_o === 1'b1) drq_cnt++;
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // expected byte i of any sector of log a; checksum bytes are judged by sum
  function automatic logic [7:0] exp_byte(input logic [7:0] a, input int i);
    int n, e, o;
    logic [15:0] c;
    n = i / 2;
    e = (i - 4) / 124;
    o = (i - 4) % 124;
    c = 16'h0000;
    if (a == `LOG_DIR) begin
      if (n == 3 || n == 7) c = 16'h0001;
      if (n >= 'h80 && n <= 'h9F) c = 16'h0010;
      if (n == 0) c = 16'h0001;
      return (i % 2) ? c[15:8] : c[7:0];
    end
    if (a == `LOG_ERR) begin
      c = nerr[15:0];
      if (i == 2) return (nerr == 0) ? 8'h00 : 8'((nerr - 1) % 4 + 1);
      if (i == 'h1F4) return c[7:0];
      if (i == 'h1F5) return c[15:8];
      if (i >= 4 && e < 4 && e < nerr && o == 'h5B) return ereg[e];
      if (i >= 4 && e < 4 && e < nerr && o == 'h65) return estat[e];
    end
    if (i == 0 && (a == `LOG_ERR || a == `LOG_TEST)) return 8'h01;
    return 8'h00;
  endfunction : exp_byte

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // one command; waits are bounded so a hang shows as a mismatch
  task automatic run_cmd(input logic [7:0] a, input logic [15:0] cnt, input logic [15:0] first,
                         input bit ab);
    int base, w, n, i;
    logic [7:0] sum;
    bit cs;
    base = drq_cnt;
    n = ab ? 0 : 512 * cnt;
    cs = (a == `LOG_ERR || a == `LOG_TEST);
    sink.rx_q.delete();
    log_addr_i = a;
    {scnt_prev_i, scnt_cur_i} = cnt;
    {first_prev_i, first_cur_i} = first;
    cmd_start_i = 1'b1;
    @(negedge core_clk_i);
    cmd_start_i = 1'b0;
    // busy rises at the taking edge, abort follows one edge later
    check("busy", 16'h1, busy_o);
    @(negedge core_clk_i);
    check("abort", 16'(ab), abort_o);
    w = 0;
    while (done_o !== 1'b1 && abort_o !== 1'b1 && w < 20000) begin
      @(negedge core_clk_i);
      w++;
    end
    while (sink.rx_q.size() < n && w < 20000) begin
      @(negedge core_clk_i);
      w++;
    end
    repeat (4) @(negedge core_clk_i);
    check("wait bound", 16'h0, 16'(w >= 20000));
    check("block interrupts", 16'(ab ? 0 : cnt), 16'(drq_cnt - base));
    check("byte total", 16'(n), 16'(sink.rx_q.size()));
    for (int k = 0; k < sink.rx_q.size(); k++) begin
      i = k % 512;
      if (i == 0) sum = 8'h00;
      sum = sum + sink.rx_q[k];
      if (cs && i == 511) check("sector sum", 16'h0, sum);
      else check("log byte", exp_byte(a, i), sink.rx_q[k]);
    end
  endtask : run_cmd

  task automatic put_err(input bit faulty);
    rnd = lfsr_next(rnd);
    err_reg_i = rnd[7:0];
    err_status_i = rnd[15:8];
    err_faulty_i = faulty;
    err_event_i = 1'b1;
    if (!faulty) begin
      ereg[nerr % 4] = rnd[7:0];
      estat[nerr % 4] = rnd[15:8];
      nerr++;
    end
    @(negedge core_clk_i);
    err_event_i = 1'b0;
    // one idle cycle so back-to-back reports never retoggle the strobe
    @(negedge core_clk_i);
  endtask : put_err

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [15:0] f, c;
    {cmd_start_i, err_event_i, err_faulty_i, stall} = 4'h0;
    {log_addr_i, scnt_cur_i, scnt_prev_i, first_cur_i, first_prev_i} = 40'h0;
    {err_reg_i, err_status_i} = 16'h0;
    smart_en_i = 1'b1;
    reset_i = 1'b1;
    rnd = 16'h7497;
    nerr = 0;
    for (int e = 0; e < 4; e++) {ereg[e], estat[e]} = 16'h0;
    repeat (16) @(negedge core_clk_i);
    reset_i = 1'b0;
    @(negedge core_clk_i);
    run_cmd(`LOG_DIR, 16'h1, 16'h0, 1'b0);
    run_cmd(`LOG_ERR, 16'h1, 16'h0, 1'b0);
    for (int k = 0; k < 8; k++) run_cmd(ab_a[k], ab_c[k], ab_f[k], 1'b1);
    smart_en_i = 1'b0;
    run_cmd(`LOG_ERR, 16'h1, 16'h0, 1'b1);
    run_cmd(`LOG_VEND_LO, 16'h1, 16'h0, 1'b1);
    smart_en_i = 1'b1;
    for (int k = 0; k < 6; k++) put_err(k == 2);
    run_cmd(`LOG_ERR, 16'h1, 16'h0, 1'b0);
    run_cmd(`LOG_TEST, 16'h1, 16'h0, 1'b0);
    run_cmd(`LOG_VEND_HI, 16'h1, 16'hF, 1'b0);
    run_cmd(`LOG_VEND_LO, 16'h2, 16'hE, 1'b0);
    // hold the consumer off so the fifo fills and generation stalls
    stall = 1'b1;
    fork
      begin
        repeat (200) @(negedge core_clk_i);
        check("stalled valid", 16'h1, data_valid_o);
        check("stalled busy", 16'h1, busy_o);
        check("stalled taken", 16'h0, 16'(sink.rx_q.size()));
        stall = 1'b0;
      end
    join_none
    run_cmd(`LOG_DIR, 16'h1, 16'h0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr_next(rnd);
      f = {12'h0, rnd[3:0]};
      c = 16'h1 + (rnd[11:8] % (16'h10 - f));
      run_cmd(8'h80 + {3'h0, rnd[15:12], 1'b0}, c, f, 1'b0);
    end
    report_and_stop();
  end

  // watchdog: whole run is well under this many cycles
  initial begin
    #(8 * 90000);
    fail_count++;
    report_and_stop();
  end
endmodule : general_purpose_log_reader_tb

/* verif/log_sink.sv */
/*
  Host-side consumer of the log byte stream, with random stalls.
  Assumes the reader's clock; ready moves only at the falling edge.
*/
`timescale 1ns/1ps
module log_sink #(
  parameter logic [15:0] SEED = 16'h7497
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // stream from the reader
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  output logic ready_o,
  // hard stall from the bench
  input wire logic stall_i
);
  logic [7:0] rx_q[$];
  logic [15:0] lfsr_q;

  initial begin
    lfsr_q = SEED;
    ready_o = 1'b0;
  end

  // ready low one cycle in four, so the fifo sees back-pressure often
  always @(negedge core_clk_i) begin
    lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    ready_o <= !stall_i && !reset_i && (lfsr_q[1:0] != 2'h0);
  end

  // a byte is taken on every rising edge with valid and ready high
  always @(posedge core_clk_i) begin
    if (valid_i === 1'b1 && ready_o) begin
      rx_q.push_back(byte_i);
    end
  end
endmodule : log_sink
